// ===== src/ebp_pkg.sv
// shared constants and types of the external bus phase sequencer
// assumes an apb master with 32-bit data and a 100 mhz pclk
package ebp_pkg;

   // ========================================
   // widths
   localparam int ADDR_W   = 24;
   localparam int DATA_W   = 16;
   localparam int APB_AW   = 8;
   localparam int APB_DW   = 32;
   localparam int TIMING_W = 14;

   // ========================================
   // register byte offsets
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_RDATA  = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_TIMING = 8'h20;

   // ========================================
   // field positions
   localparam int CMD_WRITE_BIT   = 4;
   localparam int CMD_BHE_BIT     = 5;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_DONE_BIT   = 1;

   // ========================================
   // values after reset
   localparam logic [13:0] TIMING_RST = 14'h0000;
   localparam logic [23:0] ADDR_RST   = 24'h00_0000;
   localparam logic [15:0] DATA_RST   = 16'h0000;
   localparam logic [7:0]  CMD_RST    = 8'h00;

   // ========================================
   // chip_select_timing_control layout, msb first
   typedef struct packed {
      logic       mux_mode;     // multiplexed_bus_mode when set
      logic [1:0] hold_len;     // 0..3 periods
      logic [4:0] access_len;   // value + 1 = 1..32 periods
      logic       dsetup_len;   // 0..1 period
      logic [1:0] cmd_len;      // 0..3 periods
      logic [1:0] extra_len;    // 0..3 on window change
      logic       setup_two;    // 0: one period, 1: two
   } ebp_timing_t;

   // decoded phase lengths in cpu_clock_period_unit
   typedef struct packed {
      logic [2:0] setup;
      logic [1:0] cmd;
      logic       dset;
      logic [5:0] access;
      logic [1:0] hold;
   } ebp_lens_t;

   // bus cycle phases
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_SETUP,
      PH_CMD,
      PH_DSET,
      PH_ACCESS,
      PH_HOLD
   } ebp_phase_t;

   // external pins, all registered
   typedef struct packed {
      logic              ale;
      logic              rd_n;
      logic              wr_n;
      logic              bhe_n;
      logic              ad_oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] ad_out;
   } ebp_pins_t;

endpackage

// ===== src/ebp_timing_bank.sv
// one chip_select_timing_control word per address window
// assumes writes come from the apb slave of the parent, one per cycle
`timescale 1ns/1ns
`default_nettype none
module ebp_timing_bank #(
   parameter int NUM_WIN = 4,
   parameter int WIN_W   = 2
) (
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // write port
   input  wire logic                 wr_en,
   input  wire logic [WIN_W-1:0]     wr_idx,
   input  wire ebp_pkg::ebp_timing_t wr_word,
   // all words
   output ebp_pkg::ebp_timing_t      words [NUM_WIN]
);

   // ========================================
   // per window storage
   genvar i;
   generate
      for (i = 0; i < NUM_WIN; i++) begin : g_win
         // each window keeps its word until software rewrites it
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               words[i] <= ebp_pkg::ebp_timing_t'(ebp_pkg::TIMING_RST);
            end else if (wr_en && (wr_idx == WIN_W'(i))) begin
               words[i] <= wr_word;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ===== src/ebp_phase_len.sv
// turns a timing word into phase lengths in clock periods
// assumes one period of pclk is one cpu_clock_period_unit
`timescale 1ns/1ns
`default_nettype none
module ebp_phase_len (
   // timing and window history
   input  wire ebp_pkg::ebp_timing_t timing,
   input  wire logic                 win_changed,
   // decoded lengths
   output ebp_pkg::ebp_lens_t        lens
);

   // ========================================
   // length decode
   // setup is 1..2, plus 0..3 only on the first cycle after reset or when the window moved, so 5 at most
   assign lens.setup  = 3'(timing.setup_two) + 3'h1
                        + (win_changed ? 3'(timing.extra_len) : 3'h0); // R03 R04
   assign lens.cmd    = timing.cmd_len;                                   // R05
   assign lens.dset   = timing.dsetup_len;                                // R06
   assign lens.access = 6'(timing.access_len) + 6'h01;                    // R05
   assign lens.hold   = timing.hold_len;                                  // R07

endmodule
`default_nettype wire

// ===== src/ebp_seq.sv
// external bus phase sequencer with apb register access
// assumes synchronous pin inputs, one clock pclk, apb master in front
//
// How it works
// R01 - every external cycle runs setup, command, data setup, access, hold in order; zero length command, data setup and hold phases are skipped
// R02 - each phase length comes from the selected window's timing word
// R03 - address setup lasts one or two periods by a timing bit
// R04 - a window change adds zero to three setup periods, five at most
// R05 - command delay is zero to three periods, access one to thirty-two
// R06 - a zero or one period phase gives write data setup or bus turnaround
// R07 - a hold phase of zero to three periods keeps address and write data
// R08 - read data are caught on the edge that ends access and raises read strobe
// R09 - later address changes cannot disturb the data already caught
// R10 - the memory keeps read data valid until the read strobe rises
// R11 - one phase unit is one pclk period, counters step each cycle
// R12 - read or write strobe is low only in access, rising into hold
`timescale 1ns/1ns
`default_nettype none
module ebp_seq #(
   parameter int NUM_WIN = 4,
   parameter int WIN_W   = 2
) (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ebp_pkg::APB_AW-1:0]  paddr,
   input  wire logic [ebp_pkg::APB_DW-1:0]  pwdata,
   output logic      [ebp_pkg::APB_DW-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   // external bus
   output ebp_pkg::ebp_pins_t               ext_pins,
   output logic      [NUM_WIN-1:0]          ext_cs_n,
   input  wire logic [ebp_pkg::DATA_W-1:0]  ext_ad_in
);

   // ========================================
   // declarations
   ebp_pkg::ebp_phase_t                state_reg, state_next;
   logic [5:0]                         cnt_reg, cnt_next;
   ebp_pkg::ebp_lens_t                 lens_reg, new_lens;
   logic [ebp_pkg::ADDR_W-1:0]         addr_reg, cyc_addr_reg, addr_w;
   logic [ebp_pkg::DATA_W-1:0]         wdata_reg, cyc_wdata_reg, wdata_w;
   logic [ebp_pkg::DATA_W-1:0]         rdata_reg;
   logic [7:0]                         cmd_reg;
   logic                               cyc_write_reg, cyc_bhe_reg, cyc_mux_reg;
   logic [WIN_W-1:0]                   cyc_win_reg, last_win_reg;
   logic                               last_valid_reg;
   logic                               done_reg, done_next;
   logic                               pready_reg;
   logic                               pslverr_reg;
   logic [ebp_pkg::APB_DW-1:0]         prdata_reg;
   ebp_pkg::ebp_pins_t                 pins_reg, pins_next;
   logic [NUM_WIN-1:0]                 cs_n_reg, cs_n_next;
   ebp_pkg::ebp_timing_t               tim_words [NUM_WIN];

   // ========================================
   // apb decode
   // the answer comes one cycle into the access phase; the write lands
   // only on the edge where pready is seen high, never earlier
   wire apb_first  = psel & penable & ~pready_reg;
   wire apb_commit = psel & penable & pready_reg;
   wire apb_wr     = apb_commit & pwrite;
   wire hit_cmd    = (paddr == ebp_pkg::OFS_CMD);
   wire hit_addr   = (paddr == ebp_pkg::OFS_ADDR);
   wire hit_wdata  = (paddr == ebp_pkg::OFS_WDATA);
   wire hit_rdata  = (paddr == ebp_pkg::OFS_RDATA);
   wire hit_status = (paddr == ebp_pkg::OFS_STATUS);
   wire [ebp_pkg::APB_AW-1:0] tim_off = paddr - ebp_pkg::OFS_TIMING;
   wire hit_tim    = (paddr >= ebp_pkg::OFS_TIMING) && (paddr[1:0] == 2'h0)
                     && ({2'h0, tim_off[ebp_pkg::APB_AW-1:2]} < ebp_pkg::APB_AW'(NUM_WIN));
   wire [WIN_W-1:0] tim_idx = tim_off[WIN_W+1:2];
   wire hit_any    = hit_cmd | hit_addr | hit_wdata | hit_rdata | hit_status | hit_tim;
   wire busy       = (state_reg != ebp_pkg::PH_IDLE);

   // ========================================
   // start of a cycle and window history
   wire [WIN_W-1:0] sel_win   = pwdata[WIN_W-1:0];
   // a command while busy is dropped; the cycle in flight is untouched
   wire start       = apb_wr & hit_cmd & ~busy;
   wire win_changed = ~last_valid_reg | (sel_win != last_win_reg);             // R04

   // timing of the window being started
   wire ebp_pkg::ebp_timing_t sel_tim = tim_words[sel_win];                       // R02

   ebp_timing_bank #(
      .NUM_WIN (NUM_WIN),
      .WIN_W   (WIN_W)
   ) u_bank (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (apb_wr & hit_tim),
      .wr_idx  (tim_idx),
      .wr_word (ebp_pkg::ebp_timing_t'(pwdata[ebp_pkg::TIMING_W-1:0])),
      .words   (tim_words)
   );

   ebp_phase_len u_len (
      .timing      (sel_tim),
      .win_changed (win_changed),
      .lens        (new_lens)
   );

   // ========================================
   // phase order and lengths
   // zero length phases are skipped; access is at least one period
   function automatic ebp_pkg::ebp_phase_t after_ph(input ebp_pkg::ebp_phase_t p,
                                                    input ebp_pkg::ebp_lens_t  l);
      ebp_pkg::ebp_phase_t n;
      n = ebp_pkg::PH_IDLE;
      unique case (p)
         ebp_pkg::PH_IDLE:   n = ebp_pkg::PH_IDLE;
         ebp_pkg::PH_SETUP:  n = (l.cmd != 2'h0) ? ebp_pkg::PH_CMD
                                 : (l.dset ? ebp_pkg::PH_DSET : ebp_pkg::PH_ACCESS);
         ebp_pkg::PH_CMD:    n = l.dset ? ebp_pkg::PH_DSET : ebp_pkg::PH_ACCESS;
         ebp_pkg::PH_DSET:   n = ebp_pkg::PH_ACCESS;
         ebp_pkg::PH_ACCESS: n = (l.hold != 2'h0) ? ebp_pkg::PH_HOLD : ebp_pkg::PH_IDLE;
         ebp_pkg::PH_HOLD:   n = ebp_pkg::PH_IDLE;
      endcase
      return n;
   endfunction

   function automatic logic [5:0] len_of(input ebp_pkg::ebp_phase_t p,
                                         input ebp_pkg::ebp_lens_t  l);
      logic [5:0] n;
      n = 6'h01;
      unique case (p)
         ebp_pkg::PH_IDLE:   n = 6'h01;
         ebp_pkg::PH_SETUP:  n = 6'(l.setup);
         ebp_pkg::PH_CMD:    n = 6'(l.cmd);
         ebp_pkg::PH_DSET:   n = 6'(l.dset);
         ebp_pkg::PH_ACCESS: n = l.access;
         ebp_pkg::PH_HOLD:   n = 6'(l.hold);
      endcase
      return n;
   endfunction

   // ========================================
   // sequencer next state, one count per pclk period
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (state_reg == ebp_pkg::PH_IDLE) begin
         if (start) begin
            state_next = ebp_pkg::PH_SETUP;                                       // R01
            cnt_next   = 6'(new_lens.setup) - 6'h01;                              // R03 R04
         end
      end else if (cnt_reg == 6'h00) begin
         state_next = after_ph(state_reg, lens_reg);                              // R01
         cnt_next   = len_of(state_next, lens_reg) - 6'h01;                       // R02
      end else begin
         cnt_next = cnt_reg - 6'h01;                                              // R11
      end
   end

   wire cyc_end  = busy & (state_next == ebp_pkg::PH_IDLE);
   // read data taken on the edge that leaves access, as the strobe rises
   wire rd_catch = (state_reg == ebp_pkg::PH_ACCESS) & (state_next != ebp_pkg::PH_ACCESS)
                   & ~cyc_write_reg;                                              // R08

   // ========================================
   // cycle parameters as seen by the pins on the next edge
   wire cur_write = start ? pwdata[ebp_pkg::CMD_WRITE_BIT] : cyc_write_reg;
   wire cur_bhe   = start ? pwdata[ebp_pkg::CMD_BHE_BIT] : cyc_bhe_reg;
   wire cur_mux   = start ? sel_tim.mux_mode : cyc_mux_reg;
   wire [WIN_W-1:0] cur_win = start ? sel_win : cyc_win_reg;
   assign addr_w  = start ? addr_reg : cyc_addr_reg;
   assign wdata_w = start ? wdata_reg : cyc_wdata_reg;

   // ========================================
   // pin next values, registered so every pin leaves a flip-flop
   wire act        = (state_next != ebp_pkg::PH_IDLE);
   wire nx_access  = (state_next == ebp_pkg::PH_ACCESS);
   wire drive_addr = cur_mux & (state_next == ebp_pkg::PH_SETUP);
   // write data from data setup through hold; a read leaves the bus free
   wire drive_data = act & cur_write & ((state_next == ebp_pkg::PH_DSET) | nx_access
                                        | (state_next == ebp_pkg::PH_HOLD));       // R06 R07
   assign pins_next.ale     = state_next == ebp_pkg::PH_SETUP;
   assign pins_next.rd_n    = ~(nx_access & ~cur_write);                          // R12
   assign pins_next.wr_n    = ~(nx_access & cur_write);                           // R12
   assign pins_next.bhe_n   = ~(act & cur_bhe);
   assign pins_next.ad_oe_n = ~(drive_addr | drive_data);
   // the address stays put after the cycle so hold never sees it move
   assign pins_next.addr    = act ? addr_w : pins_reg.addr;                       // R07
   assign pins_next.ad_out  = drive_addr ? addr_w[ebp_pkg::DATA_W-1:0]
                              : (drive_data ? wdata_w : pins_reg.ad_out);
   assign cs_n_next         = act ? ~(NUM_WIN'(1) << cur_win) : {NUM_WIN{1'b1}};

   // ========================================
   // read mux and sticky done
   wire [ebp_pkg::APB_DW-1:0] rd_word =
        hit_cmd    ? 32'(cmd_reg)       :
        hit_addr   ? 32'(addr_reg)      :
        hit_wdata  ? 32'(wdata_reg)     :
        hit_rdata  ? 32'(rdata_reg)     :
        hit_status ? 32'({done_reg, busy}) :
        hit_tim    ? 32'(tim_words[tim_idx]) : 32'h0000_0000;
   // a cycle ending in the clearing cycle keeps the flag set
   assign done_next = cyc_end | (done_reg & ~(apb_wr & hit_status & pwdata[ebp_pkg::STAT_DONE_BIT]));

   // ========================================
   // sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ebp_pkg::PH_IDLE;
         cnt_reg   <= 6'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // cycle parameters latched at start, so timing rewrites only hit later cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lens_reg       <= ebp_pkg::ebp_lens_t'(14'h0000);
         cyc_addr_reg   <= ebp_pkg::ADDR_RST;
         cyc_wdata_reg  <= ebp_pkg::DATA_RST;
         cyc_write_reg  <= 1'b0;
         cyc_bhe_reg    <= 1'b0;
         cyc_mux_reg    <= 1'b0;
         cyc_win_reg    <= '0;
         last_win_reg   <= '0;
         last_valid_reg <= 1'b0;
      end else if (start) begin
         lens_reg       <= new_lens;                                              // R02
         cyc_addr_reg   <= addr_reg;
         cyc_wdata_reg  <= wdata_reg;
         cyc_write_reg  <= pwdata[ebp_pkg::CMD_WRITE_BIT];
         cyc_bhe_reg    <= pwdata[ebp_pkg::CMD_BHE_BIT];
         cyc_mux_reg    <= sel_tim.mux_mode;
         cyc_win_reg    <= sel_win;
         last_win_reg   <= sel_win;                                               // R04
         last_valid_reg <= 1'b1;
      end
   end

   // captured read word, never touched by later address moves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= ebp_pkg::DATA_RST;
      end else if (rd_catch) begin
         rdata_reg <= ext_ad_in;                                                  // R08 R09 R10
      end
   end

   // software visible registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg  <= ebp_pkg::ADDR_RST;
         wdata_reg <= ebp_pkg::DATA_RST;
         cmd_reg   <= ebp_pkg::CMD_RST;
         done_reg  <= 1'b0;
      end else begin
         if (apb_wr & hit_addr) addr_reg <= pwdata[ebp_pkg::ADDR_W-1:0];
         if (apb_wr & hit_wdata) wdata_reg <= pwdata[ebp_pkg::DATA_W-1:0];
         if (start) cmd_reg <= pwdata[7:0];
         done_reg <= done_next;
      end
   end

   // apb answer, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= apb_first;
         pslverr_reg <= apb_first & ~hit_any;
         prdata_reg  <= (apb_first & ~pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // external pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_reg <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, bhe_n: 1'b1, ad_oe_n: 1'b1,
                       addr: ebp_pkg::ADDR_RST, ad_out: ebp_pkg::DATA_RST};
         cs_n_reg <= {NUM_WIN{1'b1}};
      end else begin
         pins_reg <= pins_next;
         cs_n_reg <= cs_n_next;
      end
   end

   // ========================================
   // outputs
   assign prdata   = prdata_reg;
   assign pready   = pready_reg;
   assign pslverr  = pslverr_reg;
   assign ext_pins = pins_reg;
   assign ext_cs_n = cs_n_reg;

endmodule
`default_nettype wire

// ===== bench/ebp_seq_sva.sv
// concurrent checks on the ports of the external bus phase sequencer
// assumes the bind at the foot attaches it to every ebp_seq instance
`timescale 1ns/1ns
`default_nettype none
module ebp_seq_chk #(
   parameter int NUM_WIN = 4
) (
   // clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // apb handshake
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   // external bus
   input wire ebp_pkg::ebp_pins_t ext_pins,
   input wire logic [NUM_WIN-1:0] ext_cs_n
);
   // ========================================
   // run lengths of setup and strobe, too long for a repetition
   logic [5:0] ale_run_reg;
   logic [5:0] stb_run_reg;
   wire        stb_low = !ext_pins.rd_n || !ext_pins.wr_n;
   wire        idle    = &ext_cs_n;

   // counters restart whenever the phase drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ale_run_reg <= 6'h00;
         stb_run_reg <= 6'h00;
      end else begin
         ale_run_reg <= ext_pins.ale ? ale_run_reg + 6'h01 : 6'h00;
         stb_run_reg <= stb_low ? stb_run_reg + 6'h01 : 6'h00;
      end
   end

   // ========================================
   // properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_apb_wait;
      psel && penable && !pready;
   endsequence
   sequence s_cycle_start;
      $fell(idle);
   endsequence
   sequence s_strobe_end;
      $rose(ext_pins.rd_n) || $rose(ext_pins.wr_n);
   endsequence

   property p_pready_answer; s_apb_wait |=> pready; endproperty
   property p_pready_pulse; pready |=> !pready; endproperty
   property p_slverr_with_ready; pslverr |-> pready; endproperty
   property p_strobe_excl; !(!ext_pins.rd_n && !ext_pins.wr_n); endproperty
   property p_strobe_in_cycle; stb_low |-> !idle && !ext_pins.ale; endproperty
   property p_setup_first; s_cycle_start |-> ext_pins.ale && !stb_low; endproperty
   property p_setup_max; ext_pins.ale |-> ale_run_reg < 6'h05; endproperty
   property p_access_max; stb_low |-> stb_run_reg < 6'h20; endproperty
   property p_hold_max; s_strobe_end |-> ##[0:3] idle; endproperty
   property p_addr_steady; (!idle && !$past(idle)) |-> $stable(ext_pins.addr); endproperty

   a_pready_answer: assert property (p_pready_answer) else $error("no pready");
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
   a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("pslverr alone");
   a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes");
   a_strobe_in_cycle: assert property (p_strobe_in_cycle) else $error("stray strobe");
   a_setup_first: assert property (p_setup_first) else $error("no setup first");
   a_setup_max: assert property (p_setup_max) else $error("setup too long");
   a_access_max: assert property (p_access_max) else $error("access too long");
   a_hold_max: assert property (p_hold_max) else $error("hold too long");
   a_addr_steady: assert property (p_addr_steady) else $error("address moved");
endmodule

bind ebp_seq ebp_seq_chk #(.NUM_WIN(NUM_WIN)) u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .ext_pins, .ext_cs_n);
`default_nettype wire

// ===== bench/ebp_mem_model.sv
// sixteen word memory on the external bus, indexed by low address bits
// assumes registered pins from the sequencer and the same pclk
`timescale 1ns/1ns
`default_nettype none
module ebp_mem_model #(
   parameter int NUM_WIN = 4
) (
   // clock
   input wire logic                       pclk,
   // bus from the sequencer
   input wire ebp_pkg::ebp_pins_t         ext_pins,
   input wire logic [NUM_WIN-1:0]         ext_cs_n,
   // read data back
   output logic [ebp_pkg::DATA_W-1:0]     ext_ad_in
);
   logic [15:0] mem [16];
   logic [15:0] held_reg = 16'h0000;
   wire         sel      = !(&ext_cs_n);
   wire         rd_drive = sel && !ext_pins.rd_n;
   wire  [3:0]  idx      = ext_pins.addr[3:0];

   // data only while the read strobe is low; a released bus shows no stale word
   assign ext_ad_in = rd_drive ? mem[idx] : ~held_reg;

   // last driven word remembered, writes land while the write strobe is low
   always @(posedge pclk) begin
      if (rd_drive) begin
         held_reg <= mem[idx];
      end
      if (sel && !ext_pins.wr_n) begin
         mem[idx] <= ext_pins.ad_out;
      end
   end

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'hc000 + 16'(i);
      end
   end
endmodule
`default_nettype wire

// ===== bench/tb_external_bus_cycle_phases.sv
// self-checking bench for the external bus phase sequencer
// assumes ebp_pkg, ebp_seq and the memory model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_external_bus_cycle_phases;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic               first_cyc = 1'b1;
   logic [1:0]         last_win = 2'h0;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata;
   logic [3:0]         ext_cs_n;
   logic [15:0]        ext_ad_in;
   ebp_pkg::ebp_pins_t ext_pins;
   int                 err_count, comparisons;

   ebp_seq #(.NUM_WIN(4), .WIN_W(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ext_pins, .ext_cs_n, .ext_ad_in);
   ebp_mem_model #(.NUM_WIN(4)) u_mem (.pclk, .ext_pins, .ext_cs_n, .ext_ad_in);

   // ========================================
   // clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // ========================================
   // apb master; pready looked at 1 ns after an edge, once settled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic exp_err,
                      output logic [31:0] rd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) begin
         @(posedge pclk);
         #1;
      end
      if (pready !== 1'b1) begin
         chk("pready", 32'h0000_0001, 32'h0000_0000);
         print_verdict();
      end
      rd = prdata;
      chk("pslverr", 32'(exp_err), 32'(pslverr));
      // commit edge: request still stands here, released only after it
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, a, d, 1'b0, rd);
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      apb(1'b0, a, 32'h0000_0000, exp_err, rd);
      chk(what, exp, rd);
   endtask

   // ========================================
   // one external cycle, phases measured on the pins
   task automatic run_cycle(input logic [1:0] win, input logic w, input logic hb, input ebp_pkg::ebp_timing_t t,
                            input logic [23:0] a, input logic [15:0] d);
      int s, cd, acc, h, n, exp_s;
      exp_s = 1 + t.setup_two + ((first_cyc || win != last_win) ? t.extra_len : 0);
      wr(ebp_pkg::OFS_TIMING + {4'h0, win, 2'b00}, {18'h0, t});
      wr(ebp_pkg::OFS_ADDR, {8'h00, a});
      wr(ebp_pkg::OFS_WDATA, {16'h0000, d});
      wr(ebp_pkg::OFS_CMD, {26'h0, hb, w, 2'b00, win});
      #1;
      for (n = 0; n < 100 && !(&ext_cs_n); n++) begin
         chk("cs_n", {28'h0, ~(4'h1 << win)}, {28'h0, ext_cs_n});
         chk("bhe_n", 32'(!hb), 32'(ext_pins.bhe_n));
         if (ext_pins.ale) s++;
         else if (!(w ? ext_pins.wr_n : ext_pins.rd_n)) begin
            acc++;
            chk("ad_oe_n", 32'(!w), 32'(ext_pins.ad_oe_n));
            if (w) chk("ad_out", 32'(d), 32'(ext_pins.ad_out));
         end else if (acc == 0) cd++;
         else begin
            h++;
            if (w) chk("hold_data", 32'(d), 32'(ext_pins.ad_out));
         end
         @(posedge pclk);
         #1;
      end
      if (n >= 100) begin
         chk("cycle_end", 32'h0000_0001, 32'h0000_0000);
         print_verdict();
      end
      chk("setup_len", 32'(exp_s), 32'(s));
      chk("cmd_dset_len", 32'(t.cmd_len) + 32'(t.dsetup_len), 32'(cd));
      chk("access_len", 32'(t.access_len) + 1, 32'(acc));
      chk("hold_len", 32'(t.hold_len), 32'(h));
      first_cyc = 1'b0;
      last_win = win;
      rdchk("status", ebp_pkg::OFS_STATUS, 32'h0000_0002, 1'b0);
   endtask

   // ========================================
   // scenarios
   task automatic t_reset;
      chk("pins_idle", 32'h0000_0007, 32'({ext_pins.ale, ext_pins.rd_n, ext_pins.wr_n, ext_pins.ad_oe_n}));
      chk("cs_idle", 32'h0000_000f, 32'(ext_cs_n));
      rdchk("timing0", ebp_pkg::OFS_TIMING, 32'h0000_0000, 1'b0);
      rdchk("status0", ebp_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
      rdchk("unmapped", 8'h14, 32'h0000_0000, 1'b1);
      $display("test reset done, mismatches %0d", err_count);
   endtask

   task automatic t_min_max;
      run_cycle(2'h0, 1'b1, 1'b1, '0, 24'h00_0005, 16'h1234);
      run_cycle(2'h0, 1'b0, 1'b0, ebp_pkg::ebp_timing_t'(14'h1fff), 24'h00_0005, 16'h0000);
      rdchk("rdata", ebp_pkg::OFS_RDATA, 32'h0000_1234, 1'b0);
      wr(ebp_pkg::OFS_STATUS, 32'h0000_0002);
      rdchk("done_clear", ebp_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
      $display("test min and max done, mismatches %0d", err_count);
   endtask

   task automatic t_window;
      run_cycle(2'h1, 1'b1, 1'b0, '{1'b1, 2'h1, 5'h02, 1'b1, 2'h0, 2'h3, 1'b1}, 24'h12_3407, 16'hbeef);
      run_cycle(2'h1, 1'b0, 1'b0, '{1'b1, 2'h0, 5'h00, 1'b1, 2'h1, 2'h3, 1'b1}, 24'h00_0007, 16'h0000);
      rdchk("rdata", ebp_pkg::OFS_RDATA, 32'h0000_beef, 1'b0);
      $display("test window change done, mismatches %0d", err_count);
   endtask

   task automatic t_codes;
      for (int i = 0; i < 4; i++) begin
         run_cycle(i[0] ? 2'h3 : 2'h2, 1'b1, 1'b0, '{i[1], 2'(i), 5'(i * 7), i[0], 2'(i), 2'(i), i[0]},
                   24'h00_0009, 16'(i) + 16'h5a00);
      end
      $display("test phase codes done, mismatches %0d", err_count);
   endtask

   // ========================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_min_max();
      t_window();
      t_codes();
      print_verdict();
   end
endmodule
`default_nettype wire
